// *** bert_status_pkg.sv ***
// constants and types for the receive status and interrupt-mask block
// assumes one system clock; receive-side events arrive as single-cycle pulses or levels on that clock
//
// Function
// [R01] all-ones flag bit 6 sets after 32 ones; clears only after a zero.
// [R02] all-zeros flag bit 5 sets after 32 zeros; clears only after a one.
// [R03] sync-loss flag bit 4 held while searching; after lock stays until read.
// [R04] error-seen flag bit 3 sets whenever a bit error is detected; here only for valid errored bits while in lock.
// [R05] bit-tally wrap flag bit 2 sets when the received-bit tally overflows.
// [R06] error-tally wrap flag bit 1 sets when the bit-error tally overflows.
// [R07] in-lock bit 0 is a live, unlatched copy of the synchronizer state.
// [R08] with criterion bit zero, lock drops when 6 of 64 bits err.
// [R09] status bit 7 is unassigned; host ignores it, reads zero here.
// [R10] mask bits 6..0 gate matching flags; 1 enables, 0 blocks.
// [R11] host writes zero to mask bit 7.
// [R12] status decodes at 0x14, mask at 0x15 on the parallel port.
// [R13] error and overflow flags clear on read, set again only on new event.
// [R14] sync-loss, all-ones, all-zeros clear on read only if cause is gone.
// [R15] interrupt asserts while any enabled status flag is set.
// [R16] interrupt is active low, released when no enabled flag remains.
// [R17] events arriving during a read are never lost.
package bert_status_pkg;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h14;
    localparam logic [7:0] ADDR_EVENT_MASK   = 8'h15;
    localparam int BIT_ALL_ONES    = 6;
    localparam int BIT_ALL_ZEROS   = 5;
    localparam int BIT_SYNC_LOSS   = 4;
    localparam int BIT_ERROR_SEEN  = 3;
    localparam int BIT_BIT_WRAP    = 2;
    localparam int BIT_ERR_WRAP    = 1;
    localparam int BIT_IN_LOCK     = 0;
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [6:0] FLAGS_RESET  = 7'h00;
    localparam int RUN_LENGTH   = 32;
    localparam int WINDOW_BITS  = 64;
    localparam int ERR_LIMIT    = 6;

    typedef struct packed {
        logic valid;    // one received bit this cycle
        logic data;     // received bit value
        logic err;      // received bit in error
        logic locked;   // synchronizer in lock (before error criterion)
        logic bit_wrap; // received-bit tally overflow pulse
        logic err_wrap; // bit-error tally overflow pulse
    } rx_event_type;
endpackage : bert_status_pkg

// *** bert_status_interrupt_mask.sv ***
// status flags, interrupt mask and active-low interrupt for the receiver
// assumes a synchronous parallel port: rd/wr strobes are single-cycle, address held with them
`timescale 1ns/1ps
module bert_status_interrupt_mask
    import bert_status_pkg::*;
#(
    parameter int RUN_LEN  = RUN_LENGTH,
    parameter int WIN_LEN  = WINDOW_BITS,
    parameter int ERR_LIM  = ERR_LIMIT
) (
    input  wire logic         clk_sys_i,        // system clock 100 MHz
    input  wire logic         srst_i,           // sync reset, active high
    input  wire rx_event_type rx_i,             // receive-side events
    input  wire logic         resync_criterion_select_i, // 0 = 6-of-64 lock drop
    input  wire logic [7:0]   addr_i,           // port address
    input  wire logic         rd_i,             // read strobe
    input  wire logic         wr_i,             // write strobe
    input  wire logic [7:0]   wdata_i,          // write data
    output logic [7:0]        rdata_o,          // read data, registered
    output logic              int_n_o           // interrupt, active low
);
    ////////////////////////////////////////////////////////////////////////
    localparam int RW = $clog2(RUN_LEN + 1);
    localparam int WW = $clog2(WIN_LEN + 1);
    logic [RW-1:0] ones_run;
    logic [RW-1:0] zeros_run;
    logic [WW-1:0] win_cnt;
    logic [WW-1:0] win_err;
    logic          in_lock;
    logic [6:0]    flags;
    logic [7:0]    mask;
    logic          rd_status;
    logic          ones_now;
    logic          zeros_now;
    logic [6:0]    set_ev;
    logic [6:0]    next_flags;

    assign rd_status = rd_i && (addr_i == ADDR_EVENT_STATUS); // [R12]
    assign ones_now  = (ones_run >= RW'(RUN_LEN));
    assign zeros_now = (zeros_run >= RW'(RUN_LEN));

    ////////////////////////////////////////////////////////////////////////
    // run-length counters saturate so the condition persists until a break
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ones_run  <= '0;
            zeros_run <= '0;
        end else if (rx_i.valid) begin
            if (rx_i.data) begin
                zeros_run <= '0;
                if (!ones_now) ones_run <= ones_run + RW'(1); // [R01]
            end else begin
                ones_run <= '0;
                if (!zeros_now) zeros_run <= zeros_run + RW'(1); // [R02]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // block window error check: cheaper than a sliding window, may miss straddles
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !rx_i.locked) begin
            win_cnt <= '0;
            win_err <= '0;
            in_lock <= 1'b0;
        end else begin
            if (!in_lock) begin
                in_lock <= 1'b1;
            end else if (rx_i.valid) begin
                if (win_cnt == WW'(WIN_LEN - 1)) begin
                    win_cnt <= '0;
                    win_err <= '0;
                end else begin
                    win_cnt <= win_cnt + WW'(1);
                    if (rx_i.err) win_err <= win_err + WW'(1);
                end
                if (!resync_criterion_select_i && rx_i.err
                    && (win_err >= WW'(ERR_LIM - 1))) begin
                    in_lock <= 1'b0; // [R08]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        set_ev = '0;
        set_ev[BIT_ALL_ONES]   = ones_now;                  // [R01]
        set_ev[BIT_ALL_ZEROS]  = zeros_now;                 // [R02]
        set_ev[BIT_SYNC_LOSS]  = !in_lock;                  // [R03]
        set_ev[BIT_ERROR_SEEN] = rx_i.valid && rx_i.err && in_lock; // [R04]
        set_ev[BIT_BIT_WRAP]   = rx_i.bit_wrap;             // [R05]
        set_ev[BIT_ERR_WRAP]   = rx_i.err_wrap;             // [R06]
        next_flags = flags;
        if (rd_status) begin
            next_flags = '0; // [R13] [R14]
        end
        next_flags = next_flags | set_ev; // set beats clear [R17] [R14]
        next_flags[BIT_IN_LOCK] = in_lock; // [R07]
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) flags <= FLAGS_RESET;
        else        flags <= next_flags;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mask <= MASK_RESET;
        end else if (wr_i && addr_i == ADDR_EVENT_MASK) begin
            mask <= {1'b0, wdata_i[6:0]}; // [R10] [R11]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_EVENT_STATUS: rdata_o <= {1'b0, flags}; // [R09] [R12]
                ADDR_EVENT_MASK:   rdata_o <= mask;
                default:           rdata_o <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) int_n_o <= 1'b1;
        else        int_n_o <= ~|(next_flags & mask[6:0]); // [R15] [R16]
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_read_status;
        rd_status;
    endsequence

    AST_ONES_SET: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R01]
        ones_now |=> flags[BIT_ALL_ONES]) else $error("all-ones flag not set");
    AST_ZEROS_SET: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R02]
        zeros_now |=> flags[BIT_ALL_ZEROS]) else $error("all-zeros flag not set");
    AST_LOSS_HELD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R03]
        !in_lock |=> flags[BIT_SYNC_LOSS]) else $error("sync-loss not held");
    AST_ERR_SET: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R04]
        (rx_i.valid && rx_i.err && in_lock) |=> flags[BIT_ERROR_SEEN]) else $error("error flag missed");
    AST_WRAP_SET: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R05]
        rx_i.bit_wrap |=> flags[BIT_BIT_WRAP]) else $error("bit wrap missed");
    AST_EWRAP_SET: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R06]
        rx_i.err_wrap |=> flags[BIT_ERR_WRAP]) else $error("error wrap missed");
    AST_LOCK_LIVE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R07]
        ##1 flags[BIT_IN_LOCK] == $past(in_lock)) else $error("lock bit not live");
    AST_CLEAR_ON_READ: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R13]
        (s_read_status ##0 !rx_i.err_wrap) |=> !flags[BIT_ERR_WRAP]) else $error("wrap not cleared");
    AST_MASK_BIT7: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R11]
        1'b1 |-> !mask[7]) else $error("mask bit 7 set");
    AST_INT_LEVEL: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R15]
        ##1 int_n_o == !(|($past(next_flags) & $past(mask[6:0])))) else $error("interrupt wrong");

    ////////////////////////////////////////////////////////////////////////
    // port-side steps used by the latch, read-back and mask-write checks
    sequence s_no_read;
        !rd_status;
    endsequence

    sequence s_read_mask;
        rd_i && (addr_i == ADDR_EVENT_MASK);
    endsequence

    sequence s_write_mask;
        wr_i && (addr_i == ADDR_EVENT_MASK);
    endsequence

    sequence s_read_unmapped;
        rd_i && (addr_i != ADDR_EVENT_STATUS) && (addr_i != ADDR_EVENT_MASK);
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // latched flags hold until the host reads them
    AST_ONES_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R01]
        (flags[BIT_ALL_ONES] ##0 s_no_read)
        |=> flags[BIT_ALL_ONES])
        else $error("all-ones flag dropped without read");

    AST_ZEROS_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R02]
        (flags[BIT_ALL_ZEROS] ##0 s_no_read)
        |=> flags[BIT_ALL_ZEROS])
        else $error("all-zeros flag dropped without read");

    AST_LOSS_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R03]
        (flags[BIT_SYNC_LOSS] ##0 s_no_read)
        |=> flags[BIT_SYNC_LOSS])
        else $error("sync-loss flag dropped without read");

    AST_ERR_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R04]
        (flags[BIT_ERROR_SEEN] ##0 s_no_read)
        |=> flags[BIT_ERROR_SEEN])
        else $error("error flag dropped without read");

    AST_WRAP_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R05]
        (flags[BIT_BIT_WRAP] ##0 s_no_read)
        |=> flags[BIT_BIT_WRAP])
        else $error("bit wrap flag dropped without read");

    AST_EWRAP_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R06]
        (flags[BIT_ERR_WRAP] ##0 s_no_read)
        |=> flags[BIT_ERR_WRAP])
        else $error("error wrap flag dropped without read");

    ////////////////////////////////////////////////////////////////////////
    // condition flags survive a read while their cause persists
    AST_ONES_KEEP: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R14]
        (s_read_status ##0 ones_now)
        |=> flags[BIT_ALL_ONES])
        else $error("all-ones flag cleared while ones persist");

    AST_ZEROS_KEEP: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R14]
        (s_read_status ##0 zeros_now)
        |=> flags[BIT_ALL_ZEROS])
        else $error("all-zeros flag cleared while zeros persist");

    AST_LOSS_KEEP: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R14]
        (s_read_status ##0 !in_lock)
        |=> flags[BIT_SYNC_LOSS])
        else $error("sync-loss flag cleared while searching");

    AST_ONES_CLEAR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R14]
        (s_read_status ##0 !ones_now)
        |=> !flags[BIT_ALL_ONES])
        else $error("all-ones flag not cleared on read");

    AST_ZEROS_CLEAR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R14]
        (s_read_status ##0 !zeros_now)
        |=> !flags[BIT_ALL_ZEROS])
        else $error("all-zeros flag not cleared on read");

    AST_LOSS_CLEAR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R14]
        (s_read_status ##0 in_lock)
        |=> !flags[BIT_SYNC_LOSS])
        else $error("sync-loss flag not cleared on read");

    ////////////////////////////////////////////////////////////////////////
    // event flags clear on read and stay clear until the event recurs
    AST_ERR_CLEAR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R13]
        (s_read_status ##0 !(rx_i.valid && rx_i.err && in_lock))
        |=> !flags[BIT_ERROR_SEEN])
        else $error("error flag not cleared on read");

    AST_WRAP_CLEAR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R13]
        (s_read_status ##0 !rx_i.bit_wrap)
        |=> !flags[BIT_BIT_WRAP])
        else $error("bit wrap flag not cleared on read");

    AST_ERR_IDLE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R13]
        (!flags[BIT_ERROR_SEEN] && !(rx_i.valid && rx_i.err && in_lock))
        |=> !flags[BIT_ERROR_SEEN])
        else $error("error flag set without an error");

    AST_WRAP_IDLE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R13]
        (!flags[BIT_BIT_WRAP] && !rx_i.bit_wrap)
        |=> !flags[BIT_BIT_WRAP])
        else $error("bit wrap flag set without overflow");

    AST_EVENT_IN_READ: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R17]
        (s_read_status ##0 rx_i.bit_wrap)
        |=> flags[BIT_BIT_WRAP])
        else $error("event lost during status read");

    ////////////////////////////////////////////////////////////////////////
    // lock tracking
    AST_LOCK_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R07]
        !rx_i.locked
        |=> !in_lock)
        else $error("lock kept after synchronizer lost it");

    AST_LOCK_RISE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R07]
        (rx_i.locked && !in_lock)
        |=> in_lock)
        else $error("lock not declared");

    AST_CRIT_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R08]
        (resync_criterion_select_i && rx_i.locked && in_lock)
        |=> in_lock)
        else $error("lock dropped with error criterion off");

    ////////////////////////////////////////////////////////////////////////
    // register port
    AST_BIT7_ZERO: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R09]
        s_read_status
        |=> !rdata_o[7])
        else $error("status bit 7 not zero");

    AST_STATUS_READ: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R12]
        s_read_status
        |=> (rdata_o == {1'b0, $past(flags)}))
        else $error("status read data wrong");

    AST_MASK_READ: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R12]
        s_read_mask
        |=> (rdata_o == $past(mask)))
        else $error("mask read data wrong");

    AST_UNMAPPED_READ: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R12]
        s_read_unmapped
        |=> (rdata_o == 8'h00))
        else $error("unmapped read not zero");

    AST_MASK_WRITE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R10]
        s_write_mask
        |=> (mask[6:0] == $past(wdata_i[6:0])))
        else $error("mask write lost");

    AST_RDATA_STANDS: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R12]
        !rd_i
        |=> $stable(rdata_o))
        else $error("read data changed without read");

    ////////////////////////////////////////////////////////////////////////
    // interrupt pin
    AST_INT_MASKED: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R10]
        (mask[6:0] == 7'h00)
        |=> int_n_o)
        else $error("interrupt with all flags masked");

    AST_INT_RELEASE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [R16]
        ((next_flags & mask[6:0]) == 7'h00)
        |=> int_n_o)
        else $error("interrupt not released");
endmodule : bert_status_interrupt_mask

// *** host_port_model.sv ***
// host processor model driving the 8-bit parallel control port
// assumes the device samples strobe, address and data on the rising clock edge
`timescale 1ns/1ps
module host_port_model (
    input  wire logic       clk_sys_i, // system clock
    input  wire logic [7:0] rdata_i,   // device read data
    output logic [7:0]      addr_o,    // port address
    output logic            rd_o,      // read strobe
    output logic            wr_o,      // write strobe
    output logic [7:0]      wdata_o    // write data
);
    initial begin
        addr_o = 8'h00;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    // each access waits an edge first, so a strobe never drops and rises in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 addr_o = a;
        wdata_o = {1'b0, d[6:0]};
        wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1 wr_o = 1'b0;
        wdata_o = ~wdata_o;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        #1 addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1 rd_o = 1'b0;
        d = rdata_i;
    endtask : rd
endmodule : host_port_model

// *** test_bert_status_interrupt_mask.sv ***
// self-checking bench for the status flags, mask and interrupt
// assumes host_port_model drives the port; rx events come from here
`timescale 1ns/1ps
module test_bert_status_interrupt_mask;
    import bert_status_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
    logic         clk_sys_i = 1'b0;
    logic         srst_i, rd, wr, int_n;
    logic         resync_sel = 1'b0;
    rx_event_type rx;
    logic [7:0]   addr, wdata, rdata, v;
    int           error_cnt = 0, samples_checked = 0, cyc = 0;
    row_type      rows [3] = '{'{8'h15, 8'h7F, 8'h7F}, '{8'h15, 8'h2A, 8'h2A}, '{8'h16, 8'h55, 8'h00}};
    bert_status_interrupt_mask u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .rx_i(rx),
        .resync_criterion_select_i(resync_sel), .addr_i(addr), .rd_i(rd), .wr_i(wr),
        .wdata_i(wdata), .rdata_o(rdata), .int_n_o(int_n));
    host_port_model u_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr),
        .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick
    // bit 7 is unassigned and reads zero, but the host ignores it, so it is dropped
    task automatic rs(input logic [7:0] e);
        u_host.rd(ADDR_EVENT_STATUS, v);
        chk("event_status", e, {1'b0, v[6:0]});
    endtask : rs
    initial begin
        rx = '0;
        srst_i = 1'b1;
        repeat (16) @(posedge clk_sys_i);
        #1 srst_i = 1'b0;
        chk("int_n", 8'h01, {7'h00, int_n});
        rs(8'h10);
        u_host.rd(ADDR_EVENT_MASK, v);
        chk("event_interrupt_mask", MASK_RESET, v);
        foreach (rows[i]) begin
            u_host.wr(rows[i].a, rows[i].d);
            u_host.rd(rows[i].a, v);
            chk("mask_row", rows[i].e, v);
        end
        $display("test registers done");
        rx = 6'h04;
        u_host.wr(ADDR_EVENT_MASK, 8'h01);
        tick(2);
        chk("int_n", 8'h00, {7'h00, int_n});
        rs(8'h11);
        rs(8'h01);
        u_host.wr(ADDR_EVENT_MASK, 8'h06);
        rx = 6'h06;
        tick(1);
        rx = 6'h04;
        tick(1);
        chk("int_n", 8'h00, {7'h00, int_n});
        rs(8'h05);
        rs(8'h01);
        chk("int_n", 8'h01, {7'h00, int_n});
        rx = 6'h2D;
        tick(1);
        rx = 6'h04;
        rs(8'h0B);
        rs(8'h01);
        $display("test events done");
        rx = 6'h34;
        tick(31);
        rx = 6'h24;
        tick(1);
        rx = 6'h04;
        rs(8'h01);
        rx = 6'h34;
        tick(32);
        rs(8'h41);
        rs(8'h41);
        rx = 6'h24;
        tick(1);
        rx = 6'h04;
        rs(8'h41);
        rs(8'h01);
        $display("test runs done");
        // overflow pulse lands on the very edge that samples the read strobe
        fork
            u_host.rd(ADDR_EVENT_STATUS, v);
            begin
                tick(1);
                rx = 6'h06;
                tick(1);
                rx = 6'h04;
            end
        join
        chk("event_status", 8'h01, {1'b0, v[6:0]});
        rs(8'h05);
        rs(8'h01);
        resync_sel = 1'b1;
        rx = 6'h2C;
        tick(6);
        rx = 6'h04;
        rs(8'h09);
        resync_sel = 1'b0;
        rx = 6'h00;
        tick(1);
        rx = 6'h04;
        tick(1);
        rx = 6'h2C;
        tick(6);
        rx = 6'h04;
        rs(8'h18);
        rs(8'h01);
        $display("test lock done");
        end_sim();
    end
endmodule : test_bert_status_interrupt_mask
